/* File: plms_pkg.sv */
package plms_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_TIME = 1;
    localparam int MS_CYC = CLK_HZ / 1000 * MS_TIME;
    localparam int DET_LIMIT_MS = 500;
    localparam int SLEEP_JIT_NEG_MS = 80;
    localparam int SLEEP_JIT_POS_MS = 60;
    localparam int SLEEP_JIT_SPAN = SLEEP_JIT_NEG_MS + SLEEP_JIT_POS_MS + 1;
    localparam int BURST_GAP_MS = 16;
    localparam int BURST_MAX = 3;
    localparam logic [15:0] SLEEP_MS [4] = '{16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0};
    localparam logic [15:0] WAKE_MS [4] = '{16'h0010, 16'h0030, 16'h0060, 16'h00c0};
    localparam logic [15:0] LINK_TO_MS [4] = '{16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0};

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADR_BASIC_CTRL = 8'h00;
    localparam logic [7:0] ADR_BASIC_STAT = 8'h04;
    localparam logic [7:0] ADR_MEDIA_CTRL = 8'h08;
    localparam logic [7:0] ADR_EXT_CTRL1 = 8'h0c;
    localparam logic [7:0] ADR_INLINE_CTRL = 8'h10;
    localparam logic [7:0] ADR_INT_STAT = 8'h14;
    localparam logic [7:0] ADR_POWER_CTRL = 8'h18;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BC_AN_EN_BIT = 12;
    localparam int BS_LINK_BIT = 2;
    localparam int MC_MODE_LSB = 8;
    localparam int MC_PREF_BIT = 11;
    localparam int E1_SLEEP_LSB = 13;
    localparam int E1_WAKE_LSB = 11;
    localparam int E1_MEDIA_LSB = 6;
    localparam int IC_DET_EN_BIT = 10;
    localparam int IC_DET_ST_LSB = 8;
    localparam int IS_DET_BIT = 9;
    localparam int PC_TO_HI_BIT = 7;
    localparam int PC_LPS_EN_BIT = 6;
    localparam int PC_TO_LO_BIT = 2;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic AN_EN_RST = 1'b1;
    localparam logic PREF_RST = 1'b0;
    localparam logic [2:0] MODE_RST = 3'h6;
    localparam logic [1:0] SLEEP_RST = 2'h1;
    localparam logic [1:0] WAKE_RST = 2'h1;
    localparam logic [1:0] LINK_TO_RST = 2'h1;
    localparam logic LPS_EN_RST = 1'b0;
    localparam logic [2:0] MODE_SER_PCS = 3'h6;
    localparam logic [2:0] MODE_SER_PASS = 3'h5;
    localparam logic [2:0] MODE_FX = 3'h7;
    localparam logic [1:0] MEDIA_NONE = 2'h0;
    localparam logic [1:0] MEDIA_COPPER = 2'h1;
    localparam logic [1:0] MEDIA_SERIAL = 2'h2;
    localparam logic [1:0] DET_ST_SEARCH = 2'h0;
    localparam logic [1:0] DET_ST_FOUND = 2'h1;
    localparam logic [1:0] DET_ST_NONE = 2'h2;

    typedef enum logic [1:0] {LPS_OFF, LPS_SLEEP, LPS_WAKE, LPS_NORMAL} plms_lps_t;
    typedef enum logic [1:0] {DET_IDLE, DET_LOOK, DET_AN} plms_det_t;

endpackage

/* File: plms_sync.sv */
`timescale 1ns/1ps
module plms_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // levels
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    // ****************************************
    // two stage synchroniser
    // ****************************************
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: plms_top.sv */
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module plms_top
    import plms_pkg::*;
#(
    parameter int MS_CYCLES = plms_pkg::MS_CYC,
    parameter int DET_MS = plms_pkg::DET_LIMIT_MS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // media status pins
    input wire logic copper_link_i,
    input wire logic copper_try_i,
    input wire logic serial_link_i,
    input wire logic energy_i,
    input wire logic flp_loop_i,
    // media control
    output logic copper_en_o,
    output logic serial_en_o,
    output logic [1:0] media_sel_o,
    output logic an_run_o,
    output logic pd_flp_o,
    output logic management_interrupt_o,
    // power save
    output logic low_power_o,
    output logic wake_burst_o,
    output logic wake_pair_b_o
);
    import plms_pkg::*;

    if (MS_CYCLES < 1 || MS_CYCLES >= (1 << 24)) $error("ms prescale out of range");
    if (DET_MS < 1 || DET_MS >= (1 << 16)) $error("detection limit out of range");

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pins_s;
    logic cu_link, cu_try, ser_link, energy, flp_loop;

    plms_sync #(.WIDTH(5)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({copper_link_i, copper_try_i, serial_link_i, energy_i, flp_loop_i}),
        .q_o(pins_s)
    );
    assign {cu_link, cu_try, ser_link, energy, flp_loop} = pins_s;

    // ****************************************
    // control registers
    // ****************************************
    logic an_en, pref_serial, det_en, lps_en, det_irq;
    logic [2:0] media_mode;
    logic [1:0] sleep_sel, wake_sel, link_to_sel, det_st;
    logic req, wr_fire, rd_fire;

    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_ack_o & wb_we_i;
    assign rd_fire = req & wb_ack_o & ~wb_we_i;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [15:0] wr_bc, wr_mc, wr_e1, wr_ic, wr_pc;
    assign wr_bc = merge({3'h0, an_en, 12'h000}, wb_dat_i, wb_sel_i);
    assign wr_mc = merge({4'h0, pref_serial, media_mode, 8'h00}, wb_dat_i, wb_sel_i);
    assign wr_e1 = merge({1'b0, sleep_sel, wake_sel, 11'h000}, wb_dat_i, wb_sel_i);
    assign wr_ic = merge({5'h00, det_en, 10'h000}, wb_dat_i, wb_sel_i);
    assign wr_pc = merge({8'h00, link_to_sel[1], lps_en, 3'h0, link_to_sel[0], 2'h0},
                         wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            an_en <= AN_EN_RST;
            pref_serial <= PREF_RST;
            media_mode <= MODE_RST;
            sleep_sel <= SLEEP_RST;
            wake_sel <= WAKE_RST;
            det_en <= 1'b0;
            lps_en <= LPS_EN_RST;
            link_to_sel <= LINK_TO_RST;
        end else if (ce_i && wr_fire) begin
            unique case (wb_adr_i)
                ADR_BASIC_CTRL: an_en <= wr_bc[BC_AN_EN_BIT];
                ADR_MEDIA_CTRL: begin
                    pref_serial <= wr_mc[MC_PREF_BIT];
                    media_mode <= wr_mc[MC_MODE_LSB +: 3];
                end
                ADR_EXT_CTRL1: begin
                    sleep_sel <= wr_e1[E1_SLEEP_LSB +: 2];
                    wake_sel <= wr_e1[E1_WAKE_LSB +: 2];
                end
                ADR_INLINE_CTRL: det_en <= wr_ic[IC_DET_EN_BIT];
                ADR_POWER_CTRL: begin
                    lps_en <= wr_pc[PC_LPS_EN_BIT];
                    link_to_sel <= {wr_pc[PC_TO_HI_BIT], wr_pc[PC_TO_LO_BIT]};
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // automatic media selection
    // ****************************************
    logic ams_mode, pass_mode, link_up;
    logic [1:0] next_media;

    assign ams_mode = (media_mode == MODE_SER_PCS) || (media_mode == MODE_SER_PASS) ||
                      (media_mode == MODE_FX);
    assign pass_mode = media_mode == MODE_SER_PASS;

    always_comb begin
        next_media = MEDIA_NONE;
        if (!ams_mode) begin
            next_media = cu_link ? MEDIA_COPPER : MEDIA_NONE;
        end else if (pref_serial) begin
            if (ser_link) next_media = MEDIA_SERIAL;
            else if (cu_link) next_media = MEDIA_COPPER;
        end else begin
            if (cu_link || cu_try) next_media = MEDIA_COPPER;
            else if (ser_link) next_media = MEDIA_SERIAL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            media_sel_o <= MEDIA_NONE;
            copper_en_o <= 1'b1;
            serial_en_o <= 1'b0;
        end else if (ce_i) begin
            media_sel_o <= next_media;
            // copper may not link while a preferred serial link exists
            copper_en_o <= !(ams_mode && pref_serial && ser_link);
            serial_en_o <= ams_mode && (pref_serial || !(cu_link || cu_try));
        end
    end

    // pass-through hides the serial side from the standard status
    assign link_up = pass_mode ? cu_link :
                     (media_sel_o == MEDIA_COPPER) ? cu_link :
                     (media_sel_o == MEDIA_SERIAL) ? ser_link : 1'b0;

    // ****************************************
    // millisecond tick and random source
    // ****************************************
    logic [23:0] pre_cnt;
    logic ms_tick;
    logic [7:0] lfsr;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= '0;
            ms_tick <= 1'b0;
        end else if (ce_i) begin
            ms_tick <= pre_cnt == 24'(MS_CYCLES - 1);
            pre_cnt <= (pre_cnt == 24'(MS_CYCLES - 1)) ? '0 : pre_cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) lfsr <= 8'h01;
        else if (ce_i) lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end

    // ****************************************
    // powered device detection
    // ****************************************
    plms_det_t det_state;
    logic [15:0] det_ms;
    logic det_active, link_seen, det_set;

    assign det_active = det_en & an_en;
    assign det_set = ce_i && det_state == DET_LOOK && det_active && flp_loop &&
                     det_st != DET_ST_FOUND;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_state <= DET_IDLE;
            det_st <= DET_ST_SEARCH;
            det_ms <= '0;
            link_seen <= 1'b0;
        end else if (ce_i) begin
            unique case (det_state)
                DET_IDLE: begin
                    det_ms <= '0;
                    link_seen <= 1'b0;
                    if (det_active) begin
                        det_state <= DET_LOOK;
                        det_st <= DET_ST_SEARCH;
                    end
                end
                DET_LOOK: begin
                    if (!det_active) begin
                        det_state <= DET_IDLE;
                    end else if (flp_loop) begin
                        det_st <= DET_ST_FOUND;
                        det_ms <= '0;
                    end else if (det_ms >= 16'(DET_MS)) begin
                        det_st <= DET_ST_NONE;
                        det_state <= DET_AN;
                        link_seen <= 1'b0;
                    end else if (ms_tick) begin
                        det_ms <= det_ms + 16'h0001;
                    end
                end
                DET_AN: begin
                    if (!det_active) begin
                        det_state <= DET_IDLE;
                    end else if (link_up) begin
                        link_seen <= 1'b1;
                    end else if (link_seen) begin
                        det_state <= DET_LOOK;
                        det_st <= DET_ST_SEARCH;
                        det_ms <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_flp_o <= 1'b0;
            an_run_o <= 1'b0;
        end else if (ce_i) begin
            pd_flp_o <= det_state == DET_LOOK;
            an_run_o <= an_en && det_state != DET_LOOK;
        end
    end

    // set wins over the read that clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) det_irq <= 1'b0;
        else if (det_set) det_irq <= 1'b1;
        else if (ce_i && rd_fire && wb_adr_i == ADR_INT_STAT) det_irq <= 1'b0;
    end
    assign management_interrupt_o = det_irq;

    // ****************************************
    // link idle power save
    // ****************************************
    plms_lps_t lps_state;
    logic [15:0] lps_ms, sleep_tgt, jit;
    logic [1:0] bursts;
    logic [7:0] lfsr_w;

    assign lfsr_w = (lfsr >= 8'(SLEEP_JIT_SPAN)) ? lfsr - 8'(SLEEP_JIT_SPAN) : lfsr;
    assign jit = {8'h00, lfsr_w};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lps_state <= LPS_SLEEP;
            lps_ms <= '0;
            sleep_tgt <= SLEEP_MS[SLEEP_RST];
            bursts <= '0;
            wake_burst_o <= 1'b0;
            wake_pair_b_o <= 1'b0;
        end else if (ce_i) begin
            wake_burst_o <= 1'b0;
            unique case (lps_state)
                LPS_OFF: begin
                    lps_ms <= '0;
                    sleep_tgt <= SLEEP_MS[sleep_sel] + jit - 16'(SLEEP_JIT_NEG_MS);
                    if (lps_en) lps_state <= LPS_SLEEP;
                end
                LPS_SLEEP: begin
                    if (!lps_en) begin
                        lps_state <= LPS_OFF;
                    end else if (energy) begin
                        lps_state <= LPS_NORMAL;
                        lps_ms <= '0;
                    end else if (lps_ms >= sleep_tgt) begin
                        lps_state <= LPS_WAKE;
                        lps_ms <= '0;
                        bursts <= 2'h0;
                        wake_pair_b_o <= 1'b0;
                    end else if (ms_tick) begin
                        lps_ms <= lps_ms + 16'h0001;
                    end
                end
                LPS_WAKE: begin
                    if (bursts == 2'h0) begin
                        bursts <= 2'h1;
                        wake_burst_o <= 1'b1;
                    end
                    if (!lps_en) begin
                        lps_state <= LPS_OFF;
                    end else if (energy) begin
                        lps_state <= LPS_NORMAL;
                        lps_ms <= '0;
                    end else if (lps_ms >= WAKE_MS[wake_sel]) begin
                        lps_state <= LPS_SLEEP;
                        lps_ms <= '0;
                        // random offset keeps two sleeping ends from locking step
                        sleep_tgt <= SLEEP_MS[sleep_sel] + jit - 16'(SLEEP_JIT_NEG_MS);
                    end else if (ms_tick) begin
                        lps_ms <= lps_ms + 16'h0001;
                        if (lps_ms + 16'h0001 == 16'(BURST_GAP_MS) * {14'h0, bursts} &&
                            bursts < 2'(BURST_MAX)) begin
                            bursts <= bursts + 2'h1;
                            wake_burst_o <= 1'b1;
                            wake_pair_b_o <= ~wake_pair_b_o;
                        end
                    end
                end
                LPS_NORMAL: begin
                    if (!lps_en) begin
                        lps_state <= LPS_OFF;
                    end else if (link_up || !an_en) begin
                        lps_ms <= '0;
                    end else if (lps_ms >= LINK_TO_MS[link_to_sel]) begin
                        lps_state <= LPS_SLEEP;
                        lps_ms <= '0;
                        sleep_tgt <= SLEEP_MS[sleep_sel] + jit - 16'(SLEEP_JIT_NEG_MS);
                    end else if (ms_tick) begin
                        lps_ms <= lps_ms + 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) low_power_o <= 1'b0;
        else if (ce_i) low_power_o <= lps_en && lps_state == LPS_SLEEP;
    end

    // ****************************************
    // wishbone read path
    // ****************************************
    logic [15:0] rd_val;

    always_comb begin
        rd_val = 16'h0000;
        unique case (wb_adr_i)
            ADR_BASIC_CTRL: rd_val[BC_AN_EN_BIT] = an_en;
            ADR_BASIC_STAT: rd_val[BS_LINK_BIT] = link_up;
            ADR_MEDIA_CTRL: begin
                rd_val[MC_PREF_BIT] = pref_serial;
                rd_val[MC_MODE_LSB +: 3] = media_mode;
            end
            ADR_EXT_CTRL1: begin
                rd_val[E1_SLEEP_LSB +: 2] = sleep_sel;
                rd_val[E1_WAKE_LSB +: 2] = wake_sel;
                rd_val[E1_MEDIA_LSB +: 2] = media_sel_o;
            end
            ADR_INLINE_CTRL: begin
                rd_val[IC_DET_EN_BIT] = det_en;
                rd_val[IC_DET_ST_LSB +: 2] = det_st;
            end
            ADR_INT_STAT: rd_val[IS_DET_BIT] = det_irq;
            ADR_POWER_CTRL: begin
                rd_val[PC_TO_HI_BIT] = link_to_sel[1];
                rd_val[PC_LPS_EN_BIT] = lps_en;
                rd_val[PC_TO_LO_BIT] = link_to_sel[0];
            end
            default: rd_val = 16'h0000;
        endcase
    end

    // one wait state: ack follows the first request cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) wb_dat_o <= {16'h0000, rd_val};
        end
    end
endmodule

/* File: plms_top_assertions.sv */
`timescale 1ns/1ps
module plms_top_assertions
    import plms_pkg::*;
#(
    parameter int MS_CYCLES = plms_pkg::MS_CYC,
    parameter int DET_MS = plms_pkg::DET_LIMIT_MS
) (
    // clock
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // media and power
    input wire logic energy_i,
    input wire logic copper_en_o,
    input wire logic serial_en_o,
    input wire logic [1:0] media_sel_o,
    input wire logic an_run_o,
    input wire logic pd_flp_o,
    input wire logic management_interrupt_o,
    input wire logic low_power_o,
    input wire logic wake_burst_o
);
    // ****************
    // checks
    // ****************
    logic [2:0] bursts;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // saturates so a runaway burst train cannot wrap past the limit
    always_ff @(posedge clk_i) begin
        if (rst_i || low_power_o) begin
            bursts <= 3'h0;
        end else if (wake_burst_o && bursts != 3'h7) begin
            bursts <= bursts + 3'h1;
        end
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_media_code: assert property (media_sel_o != 2'h3) else $error("bad media code");
    a_copper_allowed: assert property (media_sel_o == MEDIA_COPPER |-> copper_en_o)
        else $error("copper chosen while barred");
    a_serial_allowed: assert property (media_sel_o == MEDIA_SERIAL |-> serial_en_o)
        else $error("serial chosen while barred");
    a_det_or_an: assert property (!(pd_flp_o && an_run_o)) else $error("search and autoneg");
    a_irq_search: assert property ($rose(management_interrupt_o) |-> $past(pd_flp_o))
        else $error("interrupt outside search");
    a_burst_awake: assert property (wake_burst_o |-> !low_power_o) else $error("burst asleep");
    a_burst_limit: assert property (bursts <= 3'h3) else $error("too many bursts");
    a_energy_wake: assert property ((low_power_o && energy_i)[*4] |-> ##[1:4] !low_power_o)
        else $error("energy ignored in sleep");
    cover property ($rose(management_interrupt_o));
    cover property (wake_burst_o && bursts == 3'h2);
    cover property ($fell(copper_en_o));
endmodule
bind plms_top plms_top_assertions #(.MS_CYCLES(MS_CYCLES), .DET_MS(DET_MS)) i_plms_top_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .energy_i(energy_i), .copper_en_o(copper_en_o), .serial_en_o(serial_en_o),
    .media_sel_o(media_sel_o), .an_run_o(an_run_o), .pd_flp_o(pd_flp_o),
    .management_interrupt_o(management_interrupt_o), .low_power_o(low_power_o),
    .wake_burst_o(wake_burst_o)
);

/* File: plms_link_partner.sv */
`timescale 1ns/1ps
module plms_link_partner #(
    parameter int LINK_DLY = 8
) (
    // clock
    input wire logic clk_i,
    input wire logic rst_i,
    // bench commands
    input wire logic plug_copper_i,
    input wire logic plug_serial_i,
    input wire logic unpowered_i,
    // from the phy
    input wire logic copper_en_i,
    input wire logic pd_flp_i,
    // media pins
    output logic copper_link_o,
    output logic copper_try_o,
    output logic serial_link_o,
    output logic energy_o,
    output logic flp_loop_o
);
    int cnt;
    // copper trains first and links only while the phy allows it
    always_ff @(posedge clk_i) begin
        if (rst_i || !plug_copper_i || !copper_en_i) begin
            cnt <= 0;
        end else if (cnt < LINK_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign copper_link_o = (cnt == LINK_DLY);
    assign copper_try_o = plug_copper_i;
    assign serial_link_o = plug_serial_i;
    assign energy_o = plug_copper_i || plug_serial_i;
    // an unpowered partner echoes detection pulses
    always_ff @(posedge clk_i) begin
        flp_loop_o <= !rst_i && unpowered_i && pd_flp_i;
    end
endmodule

/* File: test_phy_link_mode_supervisor.sv */
`timescale 1ns/1ps
module test_phy_link_mode_supervisor;
    import plms_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic plug_c = 1'b0;
    logic plug_s = 1'b0;
    logic unpw = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, copper_link_i, copper_try_i, serial_link_i, energy_i, flp_loop_i;
    logic copper_en_o, serial_en_o, an_run_o, pd_flp_o, management_interrupt_o;
    logic low_power_o, wake_burst_o, wake_pair_b_o;
    logic [1:0] media_sel_o;
    logic [2:0] m;
    logic [2:0] pat;
    logic [15:0] q;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int nb;
    always #50 clk_i = ~clk_i;
    plms_top #(.MS_CYCLES(4), .DET_MS(5)) i_plms_top (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .copper_link_i(copper_link_i),
        .copper_try_i(copper_try_i), .serial_link_i(serial_link_i), .energy_i(energy_i),
        .flp_loop_i(flp_loop_i), .copper_en_o(copper_en_o), .serial_en_o(serial_en_o),
        .media_sel_o(media_sel_o), .an_run_o(an_run_o), .pd_flp_o(pd_flp_o),
        .management_interrupt_o(management_interrupt_o), .low_power_o(low_power_o),
        .wake_burst_o(wake_burst_o), .wake_pair_b_o(wake_pair_b_o));
    plms_link_partner #(.LINK_DLY(8)) i_plms_link_partner (
        .clk_i(clk_i), .rst_i(rst_i), .plug_copper_i(plug_c), .plug_serial_i(plug_s),
        .unpowered_i(unpw), .copper_en_i(copper_en_o), .pd_flp_i(pd_flp_o),
        .copper_link_o(copper_link_i), .copper_try_o(copper_try_i),
        .serial_link_o(serial_link_i), .energy_o(energy_i), .flp_loop_o(flp_loop_i));
    task wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ack is read before this edge's updates land, so no race with the slave
    task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        xfer(1'b0, a, 16'h0);
        chk(nm, e, q);
    endtask
    task settle(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task wait_lp(input logic v, input int lim);
        n = 0;
        while (low_power_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADR_BASIC_CTRL, 16'h1000, "bctl");
        rd(ADR_MEDIA_CTRL, 16'h0600, "mctl");
        rd(ADR_EXT_CTRL1, 16'h2800, "ext1");
        rd(ADR_POWER_CTRL, 16'h0004, "pwr");
        xfer(1'b1, 8'h1c, 16'hffff);
        rd(8'h1c, 16'h0000, "unmapped");
        plug_c <= 1'b1;
        plug_s <= 1'b1;
        settle(20);
        chk("sel_c", MEDIA_COPPER, media_sel_o);
        rd(ADR_EXT_CTRL1, 16'h2840, "ext1_c");
        xfer(1'b1, ADR_MEDIA_CTRL, 16'h0e00);
        settle(6);
        chk("cu_en", 1'b0, copper_en_o);
        chk("sel_s", MEDIA_SERIAL, media_sel_o);
        rd(ADR_EXT_CTRL1, 16'h2880, "ext1_s");
        plug_s <= 1'b0;
        settle(20);
        chk("sel_c2", MEDIA_COPPER, media_sel_o);
        plug_c <= 1'b0;
        plug_s <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? MODE_SER_PCS : (k == 1) ? MODE_SER_PASS : (k == 2) ? MODE_FX : 3'h0;
            xfer(1'b1, ADR_MEDIA_CTRL, {4'h0, 1'b1, m, 8'h00});
            settle(20);
            chk("ser_en", k < 3, serial_en_o);
            xfer(1'b0, ADR_BASIC_STAT, 16'h0);
            chk("link", k == 0 || k == 2, q[BS_LINK_BIT]);
        end
        xfer(1'b1, ADR_MEDIA_CTRL, 16'h0600);
        plug_s <= 1'b0;
        unpw <= 1'b1;
        xfer(1'b1, ADR_INLINE_CTRL, 16'h0400);
        settle(10);
        rd(ADR_INLINE_CTRL, 16'h0500, "found");
        chk("irq", 1'b1, management_interrupt_o);
        unpw <= 1'b0;
        settle(6);
        rd(ADR_INT_STAT, 16'h0200, "int1");
        rd(ADR_INT_STAT, 16'h0000, "int2");
        chk("irq0", 1'b0, management_interrupt_o);
        settle(40);
        rd(ADR_INLINE_CTRL, 16'h0600, "none");
        chk("an_run", 1'b1, an_run_o);
        plug_c <= 1'b1;
        settle(20);
        xfer(1'b0, ADR_BASIC_STAT, 16'h0);
        chk("link_up", 1'b1, q[BS_LINK_BIT]);
        plug_c <= 1'b0;
        settle(8);
        chk("re_search", 1'b1, pd_flp_o);
        rd(ADR_INLINE_CTRL, 16'h0400, "search");
        xfer(1'b1, ADR_INLINE_CTRL, 16'h0000);
        xfer(1'b1, ADR_EXT_CTRL1, 16'h0800);
        xfer(1'b1, ADR_POWER_CTRL, 16'h0040);
        settle(4);
        chk("sleep", 1'b1, low_power_o);
        wait_lp(1'b0, 5000);
        chk("slp_len", 1'b1, n > 3600 && n < 4300);
        nb = 0;
        pat = 3'h0;
        repeat (300) begin
            if (wake_burst_o === 1'b1) begin
                pat = {pat[1:0], wake_pair_b_o};
                nb++;
            end
            if (low_power_o !== 1'b1) begin
                @(posedge clk_i);
            end
        end
        chk("bursts", 16'h3, nb[15:0]);
        chk("pairs", 16'h2, pat);
        chk("back", 1'b1, low_power_o);
        plug_c <= 1'b1;
        settle(30);
        chk("normal", 1'b0, low_power_o);
        plug_c <= 1'b0;
        wait_lp(1'b1, 6000);
        chk("lto_len", 1'b1, n > 3900 && n < 4100);
        xfer(1'b1, ADR_BASIC_CTRL, 16'h0000);
        plug_c <= 1'b1;
        wait_lp(1'b0, 6000);
        settle(30);
        plug_c <= 1'b0;
        settle(5000);
        chk("forced", 1'b0, low_power_o);
        wrap_up();
    end
endmodule
